/* File: rtl/scg_map.svh */
// offsets, field positions and reset values of the sleep clock gate register block
`ifndef SCG_MAP_SVH
`define SCG_MAP_SVH
`define SCG_BASE_ADDR   32'h400F_E000
`define SCG_SLEEP_OFS   12'h114
`define SCG_STAT_OFS    12'h118
`define SCG_RST_VAL     32'h0000_0000
`define SCG_WR_MASK     32'h000F_1011
`define SCG_BIT_T3      19
`define SCG_BIT_T2      18
`define SCG_BIT_T1      17
`define SCG_BIT_T0      16
`define SCG_BIT_TWI     12
`define SCG_BIT_SSI     4
`define SCG_BIT_ASY     0
`define SCG_BIT_SLEEP   24
`define SCG_BIT_DEEP    25
`define SCG_BIT_AUTO    26
`endif

/* File: rtl/scg_pkg.sv */
// types and field helpers of the sleep clock gate register block
`include "scg_map.svh"
package scg_pkg;
	// unit order: 6..3 timers three..zero, 2 two-wire, 1 sync serial, 0 async serial
	typedef logic [6:0] scg_units_t;
	typedef enum logic [1:0] {SCG_RUN, SCG_SLEEP, SCG_DEEP} scg_mode_t;

	function automatic scg_units_t scg_unit_bits(input logic [31:0] w);
		return {w[`SCG_BIT_T3], w[`SCG_BIT_T2], w[`SCG_BIT_T1], w[`SCG_BIT_T0],
			w[`SCG_BIT_TWI], w[`SCG_BIT_SSI], w[`SCG_BIT_ASY]};
	endfunction : scg_unit_bits

	function automatic logic [31:0] scg_unit_word(input scg_units_t u);
		logic [31:0] w;
		w = 32'h0000_0000;
		{w[`SCG_BIT_T3], w[`SCG_BIT_T2], w[`SCG_BIT_T1], w[`SCG_BIT_T0]} = u[6:3];
		w[`SCG_BIT_TWI] = u[2];
		w[`SCG_BIT_SSI] = u[1];
		w[`SCG_BIT_ASY] = u[0];
		return w;
	endfunction : scg_unit_word
endpackage : scg_pkg

/* File: rtl/scg_acc_if.sv */
// access path between the gate control and the bus fault checker
`timescale 1ns/100ps
`default_nettype none
interface scg_acc_if;
	scg_pkg::scg_units_t gate_en;
	scg_pkg::scg_units_t access;
	logic                fault;
	modport ctl (output gate_en, output access, input fault);
	modport chk (input gate_en, input access, output fault);
endinterface : scg_acc_if
`default_nettype wire

/* File: rtl/scg_fault_chk.sv */
// bus fault detection for accesses to unclocked units
`timescale 1ns/100ps
`default_nettype none
module scg_fault_chk (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// access path
	scg_acc_if.chk    acc
);
	logic next_fault;
	logic fault_q;

	always_comb
	begin
		next_fault = |(acc.access & ~acc.gate_en); // R4
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			fault_q <= 1'b0;
		else
			fault_q <= next_fault;
	end

	assign acc.fault = fault_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_fault_gated_unit: assert property ((acc.access & ~acc.gate_en) != 7'h00 |=> acc.fault) // R4
		else $error("no fault on access to unclocked unit");
	a_no_fault_clocked: assert property ((acc.access & ~acc.gate_en) == 7'h00 |=> !acc.fault) // R4
		else $error("fault on access to clocked unit");
	c_fault_seen: cover property (acc.fault);
endmodule : scg_fault_chk
`default_nettype wire

/* File: rtl/scg_sleep_gate.sv */
// sleep mode clock gate register and gating selection
//
// Summary of operation
// R1: bits 19..16 enable timers three..zero during sleep.
// R2: bit 12 enables the two-wire unit, bit 4 the sync serial unit, bit 0 the async serial unit.
// R3: a set bit gives the unit its clock, a clear bit leaves it unclocked and disabled.
// R4: any access to a unit whose clock is off raises a bus fault.
// R5: reset clears every enable so all units start unclocked.
// R6: this register rules in sleep, companion registers rule in run and deep sleep.
// R7: sleep gating applies only with auto clock gate select set, otherwise run gating applies.
// R8: reserved bits read zero and ignore writes.
// R9: software should keep reserved bits unchanged in read-modify-write.
// R10: the register is 32 bits at offset 0x114 of the system control space.
// R11: software must enable every unit it needs in sleep.
// R12: a write lands on the next edge and takes effect at the next sleep entry.
//
// The implementer's own choice: the address-and-strobe port.
`include "scg_map.svh"
`timescale 1ns/100ps
`default_nettype none
module scg_sleep_gate (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata,
	// power mode and companion gating
	input  wire logic        auto_clock_gate_select,
	input  wire logic        sleep_mode,
	input  wire logic        deep_sleep_mode,
	input  wire logic [31:0] run_clock_gate_one,
	input  wire logic [31:0] deep_sleep_clock_gate_one,
	// unit side
	input  wire logic [6:0]  periph_access,
	output var  logic [6:0]  unit_clk_en,
	output wire logic        bus_fault
);
	logic [31:0]         sleep_clock_gate_one;
	logic [31:0]         next_sleep_clock_gate_one;
	logic [31:0]         sleep_applied;
	logic [31:0]         next_sleep_applied;
	scg_pkg::scg_mode_t  mode;
	scg_pkg::scg_mode_t  next_mode;
	scg_pkg::scg_units_t next_unit_clk_en;
	logic [31:0]         next_reg_rdata;
	logic [31:0]         eff_word;

	scg_acc_if acc_if ();

	// register decode, shared by the bus logic and the checks
	function automatic logic hits_gate_reg(input logic [11:0] a);
		return a == `SCG_SLEEP_OFS;
	endfunction : hits_gate_reg

	function automatic logic hits_status_reg(input logic [11:0] a);
		return a == `SCG_STAT_OFS;
	endfunction : hits_status_reg

	// status word: live enables plus mode flags
	function automatic logic [31:0] status_word(input scg_pkg::scg_units_t u, input scg_pkg::scg_mode_t m,
		input logic auto_sel);
		logic [31:0] w;
		w = scg_pkg::scg_unit_word(u);
		w[`SCG_BIT_SLEEP] = (m == scg_pkg::SCG_SLEEP);
		w[`SCG_BIT_DEEP]  = (m == scg_pkg::SCG_DEEP);
		w[`SCG_BIT_AUTO]  = auto_sel;
		return w;
	endfunction : status_word

	// gate register: only the enable fields take write data
	always_comb
	begin
		next_sleep_clock_gate_one = sleep_clock_gate_one;
		if (reg_wr && hits_gate_reg(reg_addr)) // R10
			next_sleep_clock_gate_one = reg_wdata & `SCG_WR_MASK; // R8 R12
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			sleep_clock_gate_one <= `SCG_RST_VAL; // R5
		else
			sleep_clock_gate_one <= next_sleep_clock_gate_one;
	end

	// power mode tracking; deep sleep wins when both levels are up
	always_comb
	begin
		if (deep_sleep_mode)
			next_mode = scg_pkg::SCG_DEEP;
		else if (sleep_mode)
			next_mode = scg_pkg::SCG_SLEEP;
		else
			next_mode = scg_pkg::SCG_RUN;
		// snapshot on entry so a write in sleep cannot glitch units already running
		next_sleep_applied = sleep_applied;
		if (mode != scg_pkg::SCG_SLEEP && next_mode == scg_pkg::SCG_SLEEP)
			next_sleep_applied = next_sleep_clock_gate_one; // R12
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sleep_applied <= `SCG_RST_VAL;
			mode          <= scg_pkg::SCG_RUN;
		end
		else
		begin
			sleep_applied <= next_sleep_applied;
			mode          <= next_mode;
		end
	end

	// unit enables: one word picked per mode, then spread over the units
	always_comb
	begin
		eff_word = run_clock_gate_one; // R7
		if (auto_clock_gate_select)
		begin
			unique case (next_mode)
				scg_pkg::SCG_RUN:   eff_word = run_clock_gate_one;
				scg_pkg::SCG_SLEEP: eff_word = next_sleep_applied; // R6
				scg_pkg::SCG_DEEP:  eff_word = deep_sleep_clock_gate_one; // R6
			endcase
		end
		next_unit_clk_en = scg_pkg::scg_unit_bits(eff_word); // R1 R2 R3
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			unit_clk_en <= 7'h00; // R5
		else
			unit_clk_en <= next_unit_clk_en;
	end

	// read data stands one cycle only, zero otherwise, so stale words never linger
	always_comb
	begin
		next_reg_rdata = 32'h0000_0000;
		if (reg_rd && hits_gate_reg(reg_addr))
			next_reg_rdata = sleep_clock_gate_one; // R8 R10
		else if (reg_rd && hits_status_reg(reg_addr))
			next_reg_rdata = status_word(unit_clk_en, mode, auto_clock_gate_select);
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= next_reg_rdata;
	end

	assign acc_if.gate_en = unit_clk_en;
	assign acc_if.access  = periph_access;
	assign bus_fault      = acc_if.fault;

	scg_fault_chk u_fault (
		.ref_clk (ref_clk),
		.rst     (rst),
		.acc     (acc_if.chk)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_reset_clears_all: assert property (disable iff (1'b0)
		rst |=> sleep_clock_gate_one == 32'h0000_0000 && unit_clk_en == 7'h00) // R5
		else $error("enables not cleared by reset");
	a_write_lands_next: assert property (reg_wr && reg_addr == `SCG_SLEEP_OFS
		|=> sleep_clock_gate_one == ($past(reg_wdata) & `SCG_WR_MASK)) // R12
		else $error("register write not taken on next edge");
	a_reserved_read_zero: assert property (reg_rd && reg_addr == `SCG_SLEEP_OFS
		|=> (reg_rdata & ~`SCG_WR_MASK) == 32'h0000_0000) // R8
		else $error("reserved bits read nonzero");
	a_read_at_offset: assert property (reg_rd && reg_addr == `SCG_SLEEP_OFS
		|=> reg_rdata == $past(sleep_clock_gate_one) ##1 reg_rdata == 32'h0000_0000 || $past(reg_rd)) // R10
		else $error("register read value wrong");
	a_timer_bit_map: assert property (!auto_clock_gate_select |=> unit_clk_en[6:3] ==
		{$past(run_clock_gate_one[19]), $past(run_clock_gate_one[18]),
		$past(run_clock_gate_one[17]), $past(run_clock_gate_one[16])}) // R1
		else $error("timer enable positions wrong");
	a_serial_bit_map: assert property (auto_clock_gate_select && sleep_mode && !deep_sleep_mode
		&& mode == scg_pkg::SCG_SLEEP |=> unit_clk_en[2:0] ==
		{$past(sleep_applied[12]), $past(sleep_applied[4]), $past(sleep_applied[0])}) // R2
		else $error("serial enable positions wrong");
	a_sleep_gates_units: assert property (auto_clock_gate_select && sleep_mode && !deep_sleep_mode
		&& mode == scg_pkg::SCG_SLEEP |=> unit_clk_en == scg_pkg::scg_unit_bits($past(sleep_applied))) // R3 R6
		else $error("sleep gating not applied");
	a_deep_uses_twin: assert property (auto_clock_gate_select && deep_sleep_mode
		|=> unit_clk_en == scg_pkg::scg_unit_bits($past(deep_sleep_clock_gate_one))) // R6
		else $error("deep sleep gating not applied");
	a_run_without_auto: assert property (!auto_clock_gate_select
		|=> unit_clk_en == scg_pkg::scg_unit_bits($past(run_clock_gate_one))) // R7
		else $error("run gating not applied without auto select");
	a_write_waits_entry: assert property (mode == scg_pkg::SCG_SLEEP && sleep_mode && !deep_sleep_mode
		&& reg_wr |=> sleep_applied == $past(sleep_applied)) // R12
		else $error("sleep write applied before next entry");
	a_entry_snapshot: assert property (mode != scg_pkg::SCG_SLEEP && sleep_mode && !deep_sleep_mode // R12
		|=> sleep_applied == sleep_clock_gate_one)
		else $error("sleep entry did not snapshot the register");
	a_reserved_never_set: assert property ((sleep_clock_gate_one & ~`SCG_WR_MASK) == 32'h0000_0000) // R8
		else $error("reserved bits hold ones");
	a_unmapped_no_write: assert property (reg_wr && !hits_gate_reg(reg_addr) // R10
		|=> $stable(sleep_clock_gate_one))
		else $error("write at other offset changed the register");
	a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) // R10
		else $error("read data not zero outside read");
	a_run_gates_units: assert property (auto_clock_gate_select && !sleep_mode && !deep_sleep_mode // R6
		|=> unit_clk_en == scg_pkg::scg_unit_bits($past(run_clock_gate_one)))
		else $error("run gating not applied in run mode");
	a_status_read: assert property (reg_rd && hits_status_reg(reg_addr) // R6
		|=> reg_rdata[19:16] == $past(unit_clk_en[6:3])
		&& reg_rdata[`SCG_BIT_SLEEP] == ($past(mode) == scg_pkg::SCG_SLEEP)
		&& reg_rdata[`SCG_BIT_AUTO] == $past(auto_clock_gate_select))
		else $error("status word wrong");

	c_sleep_entry: cover property (mode == scg_pkg::SCG_RUN ##1 mode == scg_pkg::SCG_SLEEP);
	c_write_then_sleep: cover property (reg_wr ##[1:8] mode == scg_pkg::SCG_SLEEP);
	c_deep_entry: cover property (auto_clock_gate_select && mode == scg_pkg::SCG_DEEP);
	c_status_read: cover property (reg_rd && hits_status_reg(reg_addr));
endmodule : scg_sleep_gate
`default_nettype wire

/* File: test/scg_periph_model.sv */
// peripheral side model: single access beats and a tally of bus faults
`timescale 1ns/100ps
`default_nettype none
module scg_periph_model (
	// clock
	input  wire logic       ref_clk,
	// unit side of the gate block
	input  wire logic [6:0] unit_clk_en,
	input  wire logic       bus_fault,
	output var  logic [6:0] periph_access,
	// tally for the bench
	output var  int         fault_cnt
);
	initial periph_access = 7'h00;
	initial fault_cnt = 0;
	always @(posedge ref_clk)
	begin
		if (bus_fault === 1'b1)
			fault_cnt <= fault_cnt + 1;
	end
	// one beat only: a held access would fault once per cycle
	task automatic hit(input logic [6:0] u);
		periph_access <= u;
		@(posedge ref_clk);
		periph_access <= 7'h00;
	endtask : hit
endmodule : scg_periph_model
`default_nettype wire

/* File: test/sleep_mode_clock_gate_reg_tb_top.sv */
// self-checking bench of the sleep clock gate register block
`timescale 1ns/100ps
`default_nettype none
module sleep_mode_clock_gate_reg_tb_top;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        auto_sel = 1'b0;
	logic        slp = 1'b0;
	logic        dslp = 1'b0;
	logic [31:0] run_w = 32'h0000_0000;
	logic [31:0] deep_w = 32'h0000_0000;
	logic [6:0]  acc;
	logic [6:0]  en;
	logic        flt;
	int          fcnt;
	int          n_errors = 0;
	int          checks_done = 0;
	logic [31:0] d;
	always #12.5 ref_clk = ~ref_clk;
	scg_sleep_gate uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .auto_clock_gate_select(auto_sel),
		.sleep_mode(slp), .deep_sleep_mode(dslp), .run_clock_gate_one(run_w),
		.deep_sleep_clock_gate_one(deep_w), .periph_access(acc), .unit_clk_en(en), .bus_fault(flt));
	scg_periph_model pm (.ref_clk(ref_clk), .unit_clk_en(en), .bus_fault(flt), .periph_access(acc),
		.fault_cnt(fcnt));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic t_reset();
		rd(12'h114, d);
		chk(d, 32'h0000_0000, "reset value");
		chk({25'h0, en}, 32'h0000_0000, "reset enables");
		$display("test reset done");
	endtask : t_reset
	task automatic t_regs();
		wr(12'h114, 32'hFFFF_FFFF);
		rd(12'h114, d);
		chk(d, 32'h000F_1011, "writable bits");
		wr(12'h114, 32'h0005_1001);
		wr(12'h118, 32'hFFFF_FFFF);
		rd(12'h114, d);
		chk(d, 32'h0005_1001, "bit places");
		rd(12'h100, d);
		chk(d, 32'h0000_0000, "unmapped read");
		$display("test registers done");
	endtask : t_regs
	task automatic t_modes();
		wr(12'h114, 32'h0005_1001);
		@(posedge ref_clk);
		run_w <= 32'h0000_0010;
		deep_w <= 32'h0008_0000;
		auto_sel <= 1'b1;
		slp <= 1'b1;
		settle();
		chk({25'h0, en}, 32'h0000_002D, "sleep enables");
		rd(12'h118, d);
		chk(d, 32'h0505_1001, "status in sleep");
		wr(12'h114, 32'h0000_0000);
		settle();
		chk({25'h0, en}, 32'h0000_002D, "write in sleep");
		@(posedge ref_clk);
		slp <= 1'b0;
		settle();
		chk({25'h0, en}, 32'h0000_0002, "run enables");
		@(posedge ref_clk);
		dslp <= 1'b1;
		settle();
		chk({25'h0, en}, 32'h0000_0040, "deep enables");
		@(posedge ref_clk);
		dslp <= 1'b0;
		auto_sel <= 1'b0;
		slp <= 1'b1;
		settle();
		chk({25'h0, en}, 32'h0000_0002, "sleep without auto");
		$display("test modes done");
	endtask : t_modes
	task automatic t_fault();
		int f0;
		f0 = fcnt;
		@(posedge ref_clk);
		pm.hit(7'h01);
		settle();
		chk(fcnt - f0, 1, "gated access");
		@(posedge ref_clk);
		pm.hit(7'h02);
		settle();
		chk(fcnt - f0, 1, "clocked access");
		$display("test fault done");
	endtask : t_fault
	task automatic t_rmw();
		wr(12'h114, 32'h0001_0000);
		rd(12'h114, d);
		wr(12'h114, d | 32'h0000_1000);
		rd(12'h114, d);
		chk(d, 32'h0001_1000, "read modify write");
		$display("test read modify write done");
	endtask : t_rmw
	task automatic t_rerst();
		wr(12'h114, 32'h000F_1011);
		@(posedge ref_clk);
		rst <= 1'b1;
		run_w <= 32'h0000_0000;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
	endtask : t_rerst
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_modes();
		t_fault();
		t_rmw();
		t_rerst();
		final_report();
	end
	initial
	begin
		repeat (2000) @(posedge ref_clk);
		n_errors++;
		final_report();
	end
endmodule : sleep_mode_clock_gate_reg_tb_top
`default_nettype wire
